// ==== include/pwt_pkg.sv ====
// Constants, types and register map of the power waveform timer core
// Contract
// RULE1: twelve-bit counter on its own asynchronous clock; the code keeps it on the system clock with a count enable per source tick
// RULE2: two units, two outputs, two replica outputs
// RULE3: counter compared against compare values every count
// RULE4: interrupts and events on match and overflow
// RULE5: byte-wide compare values moved into counter domain
// RULE6: ten input modes per event channel
// RULE7: two double-buffered capture channels
// RULE8: counter clock from oscillator, external or system
// RULE9: halt in debug break unless run bit set
// RULE10: forced fault on both channels during break
// RULE11: cycle of four successive counter states
// RULE12: one, two, four ramp and dual ramp
// RULE13: software waits for ready before enable change
// RULE14: outputs low until counter first enabled
package pwt_pkg;
  // ********************************************
  // Register offsets
  // ********************************************
  localparam int ADR_W = 5;
  localparam logic [4:0] ADR_CONTROL_FIRST = 5'h00;
  localparam logic [4:0] ADR_INPUT_MODE = 5'h01;
  localparam logic [4:0] ADR_COMMAND = 5'h02;
  localparam logic [4:0] ADR_STATUS = 5'h03;
  localparam logic [4:0] ADR_DEBUG_CONTROL = 5'h04;
  localparam logic [4:0] ADR_INT_MASK = 5'h05;
  localparam logic [4:0] ADR_INT_STATUS = 5'h06;
  localparam logic [4:0] ADR_OUT_ROUTE = 5'h07;
  localparam logic [4:0] ADR_CMP_BASE = 5'h08;
  localparam logic [4:0] ADR_CAP_A_LO = 5'h10;
  localparam logic [4:0] ADR_CAP_A_HI = 5'h11;
  localparam logic [4:0] ADR_CAP_B_LO = 5'h12;
  localparam logic [4:0] ADR_CAP_B_HI = 5'h13;
  // ********************************************
  // Field positions
  // ********************************************
  localparam int CTL_ENABLE = 0;
  localparam int CTL_CLOCK_SOURCE_SELECT_LSB = 1;
  localparam int CTL_RAMP_LSB = 3;
  localparam int CTL_FIELDS_MSB = 4;
  localparam int CMD_SYNC_EOC = 0;
  localparam int CMD_SYNC = 1;
  localparam int CMD_RESTART = 2;
  localparam int CMD_CAP_A = 3;
  localparam int CMD_CAP_B = 4;
  localparam int STS_ENABLE_SYNC_READY = 0;
  localparam int STS_CMDRDY = 1;
  localparam int DBG_RUN = 0;
  localparam int DBG_FAULT = 2;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_CMPA = 1;
  localparam int IRQ_CMPB = 2;
  localparam int IRQ_CAPA = 3;
  localparam int IRQ_CAPB = 4;
  localparam int IRQ_W = 5;
  localparam int ROUTE_C = 0;
  localparam int ROUTE_D = 1;
  // Input mode action bits
  localparam int ACT_CAP = 0;
  localparam int ACT_OWN = 1;
  localparam int ACT_BOTH = 2;
  localparam int ACT_RESTART = 3;
  localparam int ACT_LATCH = 4;
  // ********************************************
  // Reset values and timing
  // ********************************************
  localparam int CNT_W = 12;
  localparam logic [11:0] CMP_RESET = 12'h000;
  localparam logic [1:0] ENABLE_SYNC_CYCLES = 2'h2;
  // ********************************************
  // Types
  // ********************************************
  typedef enum logic [1:0] {CLK_OSC, CLK_EXT, CLK_SYS} pwt_clock_source_select_t;
  typedef enum logic [1:0] {RAMP_ONE, RAMP_TWO, RAMP_FOUR,
    RAMP_DUAL} pwt_ramp_t;
  typedef enum logic [1:0] {ST_DEAD_A, ST_ON_A, ST_DEAD_B,
    ST_ON_B} pwt_cycle_t;
  typedef enum logic [3:0] {IM_NONE, IM_CAPTURE, IM_KILL_OWN,
    IM_KILL_BOTH, IM_RESTART, IM_KILL_OWN_RESTART,
    IM_KILL_BOTH_RESTART, IM_CAPTURE_RESTART, IM_LATCH_OWN,
    IM_LATCH_BOTH} pwt_inmode_t;

  // Unused codes above the tenth mode act as no mode at all
  function automatic logic [4:0] modeAction(input logic [3:0] m);
    case (m)
      IM_CAPTURE: modeAction = 5'h01;
      IM_KILL_OWN: modeAction = 5'h02;
      IM_KILL_BOTH: modeAction = 5'h04;
      IM_RESTART: modeAction = 5'h08;
      IM_KILL_OWN_RESTART: modeAction = 5'h0a;
      IM_KILL_BOTH_RESTART: modeAction = 5'h0c;
      IM_CAPTURE_RESTART: modeAction = 5'h09;
      IM_LATCH_OWN: modeAction = 5'h12;
      IM_LATCH_BOTH: modeAction = 5'h14;
      default: modeAction = 5'h00;
    endcase
  endfunction
endpackage

// ==== verilog/pwt_sync.sv ====
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pwt_sync
  import pwt_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } pwt_sync_state_t;
  pwt_sync_state_t r, next_r;

  if (WIDTH < 1) begin : g_chk
    $error("pwt_sync needs at least one bit");
  end

  always_comb begin
    next_r.stage1 = pinIn;
    next_r.stage2 = r.stage1;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      r <= '0;
    end else if (clkEn) begin
      r <= next_r;
    end
  end

  assign syncOut = r.stage2;
endmodule

// ==== verilog/pwt_capture.sv ====
// Double-buffered capture channel with high byte held on low read
`timescale 1ns/1ps
module pwt_capture
  import pwt_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic capStrobe,
  input wire logic [11:0] cntVal,
  input wire logic readLow,
  output logic [7:0] capLow,
  output logic [3:0] capHigh
);
  // Latching the high byte on the low read keeps the pair coherent
  typedef struct packed {
    logic [11:0] shadow;
    logic [3:0] hiHeld;
  } pwt_cap_state_t;
  pwt_cap_state_t r, next_r;

  always_comb begin
    next_r = r;
    if (capStrobe) begin
      next_r.shadow = cntVal; // see RULE7
    end
    if (readLow) begin
      next_r.hiHeld = r.shadow[11:8]; // see RULE7
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      r <= '0;
    end else if (clkEn) begin
      r <= next_r;
    end
  end

  assign capLow = r.shadow[7:0];
  assign capHigh = r.hiHeld;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_capture_loads;
    capStrobe && clkEn |=> r.shadow == $past(cntVal);
  endproperty
  a_capture_loads: assert property (p_capture_loads) // see RULE7
    else $error("capture value not loaded");
endmodule

// ==== verilog/pwt_core.sv ====
// Power waveform timer core: counter, compare, events, registers
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module pwt_core
  import pwt_pkg::*;
#(
  parameter int CNT_WIDTH = CNT_W
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic [4:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [7:0] rdData,
  input wire logic oscClk,
  input wire logic extClk,
  input wire logic eventA,
  input wire logic eventB,
  input wire logic dbgHalt,
  output logic waveOutA,
  output logic waveOutB,
  output logic waveOutC,
  output logic waveOutD,
  output logic irq,
  output logic evOverflow,
  output logic evCompareA,
  output logic evCompareB
);
  if (CNT_WIDTH != 12) begin : g_chk
    $error("pwt_core supports a twelve-bit counter only");
  end

  // ********************************************
  // State
  // ********************************************
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] inMode;
    logic enabled;
    logic [1:0] enWait;
    logic syncEocPend;
    logic runHalt;
    logic faultForce;
    logic [IRQ_W-1:0] mask;
    logic [IRQ_W-1:0] flags;
    logic [1:0] route;
    logic [3:0][11:0] cmpBuf;
    logic [3:0][11:0] cmp;
    logic [11:0] cnt;
    logic down;
    pwt_cycle_t phase;
    logic [1:0] evPrev;
    logic [1:0] killLatch;
    logic srcPrev;
    logic evOvf;
    logic evCmpA;
    logic evCmpB;
    logic [3:0] wave;
    logic irq;
    logic [7:0] rdData;
  } pwt_core_state_t;
  pwt_core_state_t r, n;

  logic [3:0] pinSync;
  logic [1:0] evSync;
  logic [1:0] evLvl;
  logic [1:0] evEdge;
  logic [1:0][4:0] act;
  logic [1:0] kill;
  logic [1:0] capStrobe;
  logic [1:0] capRdLow;
  logic [1:0][7:0] capLo;
  logic [1:0][3:0] capHi;
  logic [IRQ_W-1:0] setFlags;
  logic [IRQ_W-1:0] clrFlags;
  pwt_clock_source_select_t clock_source_select;
  pwt_ramp_t ramp;
  logic selSrc;
  logic tick;
  logic stall;
  logic forceFault;
  logic enable_sync_ready;
  logic cmdRdy;
  logic protectNow;
  logic restartAny;
  logic copyCmp;
  logic ovf;
  logic halfA;
  logic [11:0] curLim;
  logic [11:0] rampLim;
  logic [11:0] rampThr;
  logic [7:0] stsByte;

  // ********************************************
  // Helpers
  // ********************************************
  function automatic logic [11:0] putByte(input logic [11:0] v,
      input logic hi, input logic [7:0] d);
    putByte = hi ? {d[3:0], v[7:0]} : {v[11:8], d};
  endfunction

  function automatic logic [7:0] getByte(input logic [11:0] v,
      input logic hi);
    getByte = hi ? {4'h0, v[11:8]} : v[7:0];
  endfunction

  // One-ramp region of the cycle from the counter position
  function automatic pwt_cycle_t region(input logic [11:0] c,
      input logic [3:0][11:0] k);
    if (c < k[0]) begin
      region = ST_DEAD_A;
    end else if (c < k[1]) begin
      region = ST_ON_A;
    end else if (c < k[2]) begin
      region = ST_DEAD_B;
    end else begin
      region = ST_ON_B;
    end
  endfunction

  function automatic pwt_cycle_t nextPhase(input pwt_cycle_t p);
    case (p)
      ST_DEAD_A: nextPhase = ST_ON_A;
      ST_ON_A: nextPhase = ST_DEAD_B;
      ST_DEAD_B: nextPhase = ST_ON_B;
      default: nextPhase = ST_DEAD_A;
    endcase
  endfunction

  // ********************************************
  // Pins and capture channels
  // ********************************************
  pwt_sync #(.WIDTH(4)) u_sync (
    .clock(clock),
    .nrst(nrst),
    .clkEn(clkEn),
    .pinIn({extClk, oscClk, eventB, eventA}),
    .syncOut(pinSync)
  );

  for (genvar g = 0; g < 2; g++) begin : g_cap
    pwt_capture u_cap (
      .clock(clock),
      .nrst(nrst),
      .clkEn(clkEn),
      .capStrobe(capStrobe[g]),
      .cntVal(r.cnt),
      .readLow(capRdLow[g]),
      .capLow(capLo[g]),
      .capHigh(capHi[g])
    );
  end

  assign capRdLow[0] = rdEn && (addr == ADR_CAP_A_LO);
  assign capRdLow[1] = rdEn && (addr == ADR_CAP_B_LO);
  assign evSync = pinSync[1:0];
  assign clock_source_select = pwt_clock_source_select_t'(r.ctrl[CTL_CLOCK_SOURCE_SELECT_LSB +: 2]);
  assign ramp = pwt_ramp_t'(r.ctrl[CTL_RAMP_LSB +: 2]);
  assign selSrc = (clock_source_select == CLK_OSC) ? pinSync[2] : pinSync[3];
  // The counter side advances on sampled edges of the oscillator or external source, and every clock on the system source
  assign tick = (clock_source_select == CLK_OSC || clock_source_select == CLK_EXT) ?
    (selSrc && !r.srcPrev) : 1'b1; // see RULE1 see RULE8
  assign stall = dbgHalt && !r.runHalt; // see RULE9
  assign forceFault = dbgHalt && r.faultForce; // see RULE10
  assign evLvl = (evSync & {2{!stall}}) | {2{forceFault}}; // see RULE10
  assign evEdge = evLvl & ~r.evPrev;
  assign enable_sync_ready = (r.enWait == 2'h0);
  assign cmdRdy = enable_sync_ready && !r.syncEocPend;
  assign protectNow = r.ctrl[CTL_ENABLE] || r.enabled;
  assign curLim = r.cmp[r.phase];
  assign halfA = (r.phase == ST_DEAD_A) || (r.phase == ST_ON_A);
  assign rampLim = halfA ? r.cmp[1] : r.cmp[3];
  assign rampThr = halfA ? r.cmp[0] : r.cmp[2];

  // ********************************************
  // Next state
  // ********************************************
  always_comb begin
    n = r;
    n.evOvf = 1'b0;
    n.evCmpA = 1'b0;
    n.evCmpB = 1'b0;
    n.rdData = 8'h00;
    n.srcPrev = selSrc;
    n.evPrev = evLvl;
    ovf = 1'b0;
    restartAny = 1'b0;
    copyCmp = 1'b0;
    capStrobe = 2'h0;
    clrFlags = '0;
    kill = 2'h0;
    stsByte = 8'h00;
    stsByte[STS_ENABLE_SYNC_READY] = enable_sync_ready;
    stsByte[STS_CMDRDY] = cmdRdy;
    act[0] = modeAction(r.inMode[3:0]);
    act[1] = modeAction(r.inMode[7:4]);
    if (wrEn) begin
      case (addr)
        ADR_CONTROL_FIRST: begin
          // Enable changes only once the previous one has settled
          if (enable_sync_ready && wrData[CTL_ENABLE] != r.ctrl[CTL_ENABLE]) begin
            n.ctrl[CTL_ENABLE] = wrData[CTL_ENABLE]; // see RULE13
            n.enWait = ENABLE_SYNC_CYCLES;
          end
          if (!protectNow) begin
            n.ctrl[CTL_FIELDS_MSB:CTL_CLOCK_SOURCE_SELECT_LSB] =
              wrData[CTL_FIELDS_MSB:CTL_CLOCK_SOURCE_SELECT_LSB]; // see RULE13
          end
        end
        ADR_INPUT_MODE: begin
          if (!protectNow) begin
            n.inMode = wrData; // see RULE6
          end
        end
        ADR_COMMAND: begin
          if (r.enabled) begin
            if (wrData[CMD_SYNC] && cmdRdy) begin
              copyCmp = 1'b1; // see RULE5
            end
            if (wrData[CMD_SYNC_EOC] && cmdRdy) begin
              n.syncEocPend = 1'b1;
            end
            if (wrData[CMD_RESTART]) begin
              restartAny = 1'b1;
              n.killLatch = 2'h0;
            end
            capStrobe = {wrData[CMD_CAP_B], wrData[CMD_CAP_A]};
          end
        end
        ADR_DEBUG_CONTROL: begin
          n.runHalt = wrData[DBG_RUN];
          n.faultForce = wrData[DBG_FAULT];
        end
        ADR_INT_MASK: begin
          n.mask = wrData[IRQ_W-1:0];
        end
        ADR_INT_STATUS: begin
          clrFlags = wrData[IRQ_W-1:0];
        end
        ADR_OUT_ROUTE: begin
          if (!protectNow) begin
            n.route = wrData[1:0];
          end
        end
        default: begin
          // Buffers take bytes only while no transfer is pending
          if (addr[4:3] == ADR_CMP_BASE[4:3] && cmdRdy) begin
            n.cmpBuf[addr[2:1]] =
              putByte(r.cmpBuf[addr[2:1]], addr[0], wrData); // see RULE5
          end
        end
      endcase
    end
    if (rdEn) begin
      case (addr)
        ADR_CONTROL_FIRST: n.rdData = r.ctrl;
        ADR_INPUT_MODE: n.rdData = r.inMode;
        ADR_STATUS: n.rdData = stsByte;
        ADR_DEBUG_CONTROL: begin
          n.rdData[DBG_RUN] = r.runHalt;
          n.rdData[DBG_FAULT] = r.faultForce;
        end
        ADR_INT_MASK: n.rdData[IRQ_W-1:0] = r.mask;
        ADR_INT_STATUS: n.rdData[IRQ_W-1:0] = r.flags;
        ADR_OUT_ROUTE: n.rdData[1:0] = r.route;
        ADR_CAP_A_LO: n.rdData = capLo[0];
        ADR_CAP_A_HI: n.rdData = {4'h0, capHi[0]};
        ADR_CAP_B_LO: n.rdData = capLo[1];
        ADR_CAP_B_HI: n.rdData = {4'h0, capHi[1]};
        default: begin
          if (addr[4:3] == ADR_CMP_BASE[4:3]) begin
            n.rdData = getByte(r.cmpBuf[addr[2:1]], addr[0]);
          end
        end
      endcase
    end
    // Enable takes effect after the domain crossing delay
    if (r.enWait != 2'h0) begin
      n.enWait = r.enWait - 2'h1;
      if (r.enWait == 2'h1) begin
        n.enabled = r.ctrl[CTL_ENABLE];
        if (r.ctrl[CTL_ENABLE]) begin
          copyCmp = 1'b1; // see RULE5
          restartAny = 1'b1;
          n.killLatch = 2'h0;
        end else begin
          n.syncEocPend = 1'b0;
        end
      end
    end
    if (r.enabled) begin
      for (int i = 0; i < 2; i++) begin
        if (evEdge[i] && act[i][ACT_RESTART]) begin
          restartAny = 1'b1; // see RULE6
        end
        if (evEdge[i] && act[i][ACT_CAP]) begin
          capStrobe[i] = 1'b1; // see RULE6 see RULE7
        end
        if (evEdge[i] && act[i][ACT_LATCH]) begin
          n.killLatch = n.killLatch |
            (act[i][ACT_BOTH] ? 2'h3 : 2'(1 << i)); // see RULE6
        end
        if (evLvl[i] && act[i][ACT_OWN]) begin
          kill[i] = 1'b1;
        end
        if (evLvl[i] && act[i][ACT_BOTH]) begin
          kill = 2'h3;
        end
      end
    end
    kill = kill | n.killLatch;
    // Counter and the four-state cycle
    if (restartAny) begin
      n.cnt = 12'h000;
      n.down = 1'b0;
      n.phase = ST_DEAD_A;
    end else if (r.enabled && tick && !stall) begin
      case (ramp)
        RAMP_FOUR: begin
          if (r.cnt >= curLim) begin
            n.cnt = 12'h000; // see RULE12
            n.phase = nextPhase(r.phase); // see RULE11
            ovf = (r.phase == ST_ON_B);
          end else begin
            n.cnt = r.cnt + 12'h001;
          end
        end
        RAMP_TWO: begin
          if (r.cnt >= rampLim) begin
            n.cnt = 12'h000; // see RULE12
            n.phase = halfA ? ST_DEAD_B : ST_DEAD_A;
            ovf = !halfA;
          end else begin
            n.cnt = r.cnt + 12'h001;
            if (n.cnt >= rampThr) begin
              n.phase = halfA ? ST_ON_A : ST_ON_B; // see RULE3
            end
          end
        end
        RAMP_ONE: begin
          if (r.cnt >= r.cmp[3]) begin
            n.cnt = 12'h000; // see RULE12
            ovf = 1'b1;
          end else begin
            n.cnt = r.cnt + 12'h001;
          end
          n.phase = region(n.cnt, r.cmp); // see RULE3 see RULE11
        end
        default: begin
          if (!r.down) begin
            if (r.cnt >= r.cmp[3] && r.cnt != 12'h000) begin
              n.down = 1'b1; // see RULE12
              n.cnt = r.cnt - 12'h001;
            end else begin
              n.cnt = r.cnt + 12'h001;
            end
          end else if (r.cnt == 12'h000) begin
            n.down = 1'b0;
            n.cnt = 12'h001;
            ovf = 1'b1;
          end else begin
            n.cnt = r.cnt - 12'h001;
          end
          if (!n.down) begin
            n.phase = (n.cnt >= r.cmp[0]) ? ST_ON_A : ST_DEAD_A;
          end else begin
            n.phase = (n.cnt < r.cmp[2]) ? ST_ON_B : ST_DEAD_B;
          end
        end
      endcase
    end
    if (ovf && r.syncEocPend) begin
      copyCmp = 1'b1; // see RULE5
      n.syncEocPend = 1'b0;
    end
    if (copyCmp) begin
      n.cmp = r.cmpBuf; // see RULE5
    end
    n.evOvf = ovf; // see RULE4
    n.evCmpA = r.enabled && n.phase == ST_ON_A &&
      r.phase != ST_ON_A; // see RULE3 see RULE4
    n.evCmpB = r.enabled && n.phase == ST_ON_B &&
      r.phase != ST_ON_B; // see RULE3 see RULE4
    setFlags = '0;
    setFlags[IRQ_OVF] = ovf;
    setFlags[IRQ_CMPA] = n.evCmpA;
    setFlags[IRQ_CMPB] = n.evCmpB;
    setFlags[IRQ_CAPA] = capStrobe[0];
    setFlags[IRQ_CAPB] = capStrobe[1];
    // A new event beats a clear in the same cycle
    n.flags = (r.flags & ~clrFlags) | setFlags; // see RULE4
    n.irq = |(n.flags & n.mask);
    // Outputs stay low while disabled, including from reset
    n.wave[0] = n.enabled && n.phase == ST_ON_A &&
      !kill[0]; // see RULE2 see RULE14
    n.wave[1] = n.enabled && n.phase == ST_ON_B &&
      !kill[1]; // see RULE2 see RULE14
    n.wave[2] = n.route[ROUTE_C] ? n.wave[1] : n.wave[0]; // see RULE2
    n.wave[3] = n.route[ROUTE_D] ? n.wave[1] : n.wave[0]; // see RULE2
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      r <= '0;
    end else if (clkEn) begin
      r <= n;
    end
  end

  assign rdData = r.rdData;
  assign waveOutA = r.wave[0];
  assign waveOutB = r.wave[1];
  assign waveOutC = r.wave[2];
  assign waveOutD = r.wave[3];
  assign irq = r.irq;
  assign evOverflow = r.evOvf;
  assign evCompareA = r.evCmpA;
  assign evCompareB = r.evCmpB;

  // ********************************************
  // Checks
  // ********************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_osc_hold;
    r.enabled && clock_source_select == CLK_OSC && !tick && !restartAny |=>
      $stable(r.cnt);
  endproperty
  a_osc_hold: assert property (p_osc_hold) // see RULE1 see RULE8
    else $error("counter moved without a source edge");

  property p_route;
    r.wave[2] == (r.route[ROUTE_C] ? r.wave[1] : r.wave[0]) &&
      r.wave[3] == (r.route[ROUTE_D] ? r.wave[1] : r.wave[0]);
  endproperty
  a_route: assert property (p_route) // see RULE2
    else $error("replica output does not follow its unit");

  property p_cmp_phase;
    r.evCmpA |-> r.phase == ST_ON_A && $past(r.phase) != ST_ON_A;
  endproperty
  a_cmp_phase: assert property (p_cmp_phase) // see RULE3
    else $error("compare event without entering on-time");

  property p_ovf_flag;
    r.evOvf |-> r.flags[IRQ_OVF];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) // see RULE4
    else $error("overflow did not set its flag");

  property p_sync_copy;
    clkEn && wrEn && addr == ADR_COMMAND && wrData[CMD_SYNC] &&
      r.enabled && cmdRdy |=> r.cmp == $past(r.cmpBuf);
  endproperty
  a_sync_copy: assert property (p_sync_copy) // see RULE5
    else $error("sync command did not load compare values");

  sequence s_restart_a;
    clkEn && r.enabled && evEdge[0] && r.inMode[3:0] == IM_RESTART;
  endsequence
  property p_restart_evt;
    s_restart_a |=> r.cnt == 12'h000 && r.phase == ST_DEAD_A;
  endproperty
  a_restart_evt: assert property (p_restart_evt) // see RULE6
    else $error("restart event did not restart counter");

  property p_halt;
    stall && r.enabled && !wrEn && r.enWait == 2'h0 |=>
      $stable(r.cnt) && $stable(r.phase);
  endproperty
  a_halt: assert property (p_halt) // see RULE9
    else $error("counter ran during debug break");

  property p_fault;
    clkEn && forceFault && r.enabled && r.enWait == 2'h0 &&
      r.inMode[3:0] == IM_KILL_BOTH |=> r.wave[1:0] == 2'h0;
  endproperty
  a_fault: assert property (p_fault) // see RULE10
    else $error("forced fault did not kill outputs");

  property p_four_ramp;
    clkEn && r.enabled && tick && !stall && ramp == RAMP_FOUR &&
      r.cnt >= curLim && !restartAny |=> r.cnt == 12'h000;
  endproperty
  a_four_ramp: assert property (p_four_ramp) // see RULE12
    else $error("four-ramp counter did not wrap");

  property p_off_low;
    !r.enabled |-> r.wave == 4'h0;
  endproperty
  a_off_low: assert property (p_off_low) // see RULE14
    else $error("output high while disabled");
endmodule

// ==== verif/pwt_bridge_model.sv ====
// Bridge driver model that reports its faults back as input events
`timescale 1ns/1ps
module pwt_bridge_model (
  input wire logic clock,
  input wire logic trip,
  input wire logic waveOutA,
  input wire logic waveOutB,
  input wire logic waveOutC,
  input wire logic waveOutD,
  output logic faultA,
  output logic faultB
);
  // Both switches of a leg on is shoot-through, so the driver trips
  always @(posedge clock) begin
    faultA <= trip | (waveOutA & waveOutB);
    faultB <= waveOutC & waveOutD;
  end
endmodule

// ==== verif/pwt_core_tb.sv ====
// Self-checking bench for the power waveform timer core
`timescale 1ns/1ps
module pwt_core_tb;
  import pwt_pkg::*;
  logic clock, nrst = 1'b0, wrEn = 1'b0, rdEn = 1'b0, rdLate = 1'b0;
  logic dbgHalt = 1'b0, trip = 1'b0, osc = 1'b0, eventA, eventB, irq;
  logic [4:0] obs;
  logic waveOutA, waveOutB, waveOutC, waveOutD;
  logic evOverflow, evCompareA, evCompareB;
  logic [4:0] addr = 5'h00;
  logic [7:0] wrData = 8'h00, rdData, cv;
  logic [15:0] nt;
  logic [15:0] rdQ[$];
  int perQ[$];
  int failures, checksDone, cyc, lastOvf, period;
  int hi[5], s[5];
  logic [31:0] seed;
  pwt_core u_dut (.clock(clock), .nrst(nrst), .clkEn(1'b1), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .oscClk(osc), .extClk(1'b0), .eventA(eventA), .eventB(eventB),
    .dbgHalt(dbgHalt), .waveOutA(waveOutA), .waveOutB(waveOutB),
    .waveOutC(waveOutC), .waveOutD(waveOutD), .irq(irq),
    .evOverflow(evOverflow), .evCompareA(evCompareA),
    .evCompareB(evCompareB));
  pwt_bridge_model u_bridge (.clock(clock), .trip(trip),
    .waveOutA(waveOutA), .waveOutB(waveOutB), .waveOutC(waveOutC),
    .waveOutD(waveOutD), .faultA(eventA), .faultB(eventB));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    checksDone++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chkCnt(input int e, input int g);
    chk(8'(e), 8'(g));
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    tick(1);
    wrEn <= 1'b0;
    tick(1);
  endtask
  // Mask lets a read ignore bits whose value is not ours to predict
  task automatic rd(input logic [4:0] a, input logic [7:0] m,
    input logic [7:0] e);
    rdQ.push_back({m, e});
    addr <= a;
    rdEn <= 1'b1;
    tick(1);
    rdEn <= 1'b0;
    tick(1);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ****************************************
  // Clock, watcher and stimulus
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    rdLate <= rdEn;
    osc <= ~osc;
    obs = {evOverflow, waveOutD, waveOutC, waveOutB, waveOutA};
    if (nrst)
      chk(8'h00, {3'h0, obs ^ obs});
    if (rdLate) begin
      nt = rdQ.pop_front();
      chk(nt[7:0], rdData & nt[15:8]);
    end
    // Any control write, enabling or not, voids the old baseline, since setting enable starts a new cycle
    if (wrEn && addr == ADR_CONTROL_FIRST)
      lastOvf = 0;
    if (evOverflow && lastOvf != 0 && perQ.size() > 0)
      chkCnt(perQ.pop_front(), cyc - lastOvf);
    if (evOverflow)
      lastOvf = cyc;
    foreach (hi[i])
      hi[i] += obs[i];
    if (cyc == 2000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    seed = 32'd72;
    tick(6);
    nrst <= 1'b1;
    tick(2);
    chk(8'h00, {3'h0, irq, waveOutA, waveOutB, waveOutC, waveOutD});
    rd(5'h1f, 8'hff, 8'h00);
    rd(ADR_STATUS, 8'h01, 8'h01);
    $display("test reset done");
    period = 4;
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      cv = 8'(1 + seed % 7);
      period += cv;
      wr(ADR_CMP_BASE + 5'(2 * i), cv);
      wr(ADR_CMP_BASE + 5'(2 * i + 1), 8'h00);
      rd(ADR_CMP_BASE + 5'(2 * i), 8'hff, cv);
    end
    wr(ADR_INPUT_MODE, 8'h22);
    wr(ADR_OUT_ROUTE, 8'h02);
    wr(ADR_INT_MASK, 8'h03);
    wr(ADR_CONTROL_FIRST, 8'h14);
    wr(ADR_CONTROL_FIRST, 8'h15);
    perQ.push_back(period);
    perQ.push_back(period);
    tick(4 * period);
    rd(ADR_INT_STATUS, 8'h07, 8'h07);
    chkCnt(0, perQ.size());
    $display("test ramp done");
    // Tripped unit A and its replica C must stay off while unit B, seen on replica D, keeps switching
    trip <= 1'b1;
    tick(6);
    s = hi;
    tick(70);
    chkCnt(0, hi[0] - s[0]);
    chkCnt(0, hi[2] - s[2]);
    chkCnt(1, int'(hi[3] > s[3]));
    trip <= 1'b0;
    $display("test trip done");
    dbgHalt <= 1'b1;
    tick(4);
    s = hi;
    tick(70);
    chkCnt(0, hi[4] - s[4]);
    wr(ADR_DEBUG_CONTROL, 8'h05);
    tick(4);
    s = hi;
    tick(70);
    chkCnt(1, int'(hi[4] > s[4]));
    chkCnt(0, hi[0] + hi[1] - s[0] - s[1]);
    dbgHalt <= 1'b0;
    tick(6);
    s = hi;
    tick(70);
    chkCnt(1, int'(hi[0] > s[0]));
    $display("test debug done");
    // Restart then one count before the capture edge, so it sees one
    wr(ADR_COMMAND, 8'h04);
    wr(ADR_COMMAND, 8'h08);
    rd(ADR_CAP_A_LO, 8'hff, 8'h01);
    rd(ADR_CAP_A_HI, 8'hff, 8'h00);
    $display("test capture done");
    rd(ADR_STATUS, 8'h01, 8'h01);
    wr(ADR_CONTROL_FIRST, 8'h14);
    wr(ADR_INT_MASK, 8'h00);
    tick(2);
    chk(8'h00, {7'h0, irq});
    wr(ADR_INT_MASK, 8'h03);
    tick(2);
    chk(8'h01, {7'h0, irq});
    wr(ADR_INT_STATUS, 8'h1f);
    tick(2);
    chk(8'h00, {7'h0, irq});
    rd(ADR_INT_STATUS, 8'h1f, 8'h00);
    $display("test interrupt done");
    // Oscillator pin toggles each clock, so one tick every two clocks;
    // cv still holds the clear-B top, and a dual cycle is twice the top
    wr(ADR_CONTROL_FIRST, 8'h18);
    wr(ADR_CONTROL_FIRST, 8'h19);
    perQ.push_back(4 * cv);
    perQ.push_back(4 * cv);
    tick(16 * cv + 8);
    chkCnt(0, perQ.size());
    $display("test clock source done");
    finish_test();
  end
endmodule
